// file: hw/cag_pkg.sv
package cag_pkg;

	// ----------------------------------------
	// Widths, fields and reset values
	// ----------------------------------------
	localparam int          CAG_LVL_W      = 4;
	localparam int          CAG_SEG_W      = 8;
	localparam int          CAG_PAGE_W     = 10;
	localparam int          CAG_OFS_W      = 14;
	localparam int          CAG_ENTRIES    = 5;   // Four page pointers and the bank base
	localparam int          CAG_CP_IDX     = 4;
	localparam logic [3:0]  CAG_LVL_TOP    = 4'hf;
	localparam logic [3:0]  CAG_LVL_RST    = 4'h0;
	localparam logic [7:0]  CAG_SEG_RST    = 8'h00;
	localparam logic [15:0] CAG_IP_RST     = 16'h0000;
	localparam logic [15:0] CAG_CP_RST     = 16'hfc00;
	localparam logic [15:0] CAG_CSP_MASK   = 16'h00ff;
	localparam logic [15:0] CAG_DPP_MASK   = 16'h03ff;
	localparam logic [2:0]  CAG_CP_LOW3    = 3'h0;
	localparam logic [1:0]  CAG_CP_FORCE   = 2'h3;
	localparam logic [3:0]  CAG_GPR_RANGE  = 4'hf;

	// Register selects on the internal special register port
	typedef enum logic [2:0] {
		CAG_SEL_DATA_PAGE_POINTER_0   = 3'h0,
		CAG_SEL_DATA_PAGE_POINTER_1   = 3'h1,
		CAG_SEL_DATA_PAGE_POINTER_2   = 3'h2,
		CAG_SEL_DATA_PAGE_POINTER_3   = 3'h3,
		CAG_SEL_CP     = 3'h4,
		CAG_SEL_CSP    = 3'h5,
		CAG_SEL_STATUS = 3'h6
	} cag_sel_e;

	// How many segment address pins the bus controller uses
	typedef enum logic [1:0] {
		CAG_PINS_8 = 2'h0,
		CAG_PINS_4 = 2'h1,
		CAG_PINS_2 = 2'h2
	} cag_pins_e;

	// Interrupt part of the status word
	typedef struct packed {
		logic                 global_irq_enable;
		logic [CAG_LVL_W-1:0] cpu_priority_level;
	} cag_psw_s;

endpackage : cag_pkg

// file: hw/cag_addr_gen.sv
`timescale 1ns/1ps
module cag_addr_gen (
	input  wire logic                 i_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_segmented,
	input  wire cag_pkg::cag_pins_e   i_pin_mode,
	input  wire logic                 i_instr_end,
	input  wire logic                 i_sfr_wr,
	input  wire cag_pkg::cag_sel_e    i_sfr_sel,
	input  wire logic [15:0]          i_sfr_wdata,
	input  wire cag_pkg::cag_sel_e    i_sfr_rd_sel,
	input  wire logic                 i_isr_entry,
	input  wire logic [3:0]           i_isr_level,
	input  wire logic                 i_sw_trap,
	input  wire logic                 i_interrupt_return_instr,
	input  wire cag_pkg::cag_psw_s    i_interrupt_return_instr_psw,
	input  wire logic                 i_irq_req,
	input  wire logic [3:0]           i_irq_level,
	input  wire logic                 i_hw_trap,
	input  wire logic                 i_nmi,
	input  wire logic                 i_fetch_done,
	input  wire logic [2:0]           i_fetch_bytes,
	input  wire logic                 i_branch,
	input  wire logic [15:0]          i_branch_target,
	input  wire logic                 i_ret_ip,
	input  wire logic [15:0]          i_ret_ip_value,
	input  wire logic                 i_long_xfer,
	input  wire logic                 i_seg_restore,
	input  wire logic [7:0]           i_seg_value,
	input  wire logic                 i_data_req,
	input  wire logic [15:0]          i_data_addr,
	input  wire logic                 i_data_bypass,
	input  wire logic [23:0]          i_data_far_addr,
	input  wire logic                 i_gpr_req,
	input  wire logic [7:0]           i_gpr_num,
	input  wire logic                 i_gpr_long,
	input  wire logic                 i_gpr_byte,
	output logic                      o_global_irq_enable,
	output logic [3:0]                o_cpu_priority_level,
	output logic                      o_maskable_accept,
	output logic                      o_preempt,
	output logic [15:0]               o_fetch_offset,
	output logic [23:0]               o_code_addr,
	output logic [7:0]                o_code_seg_pins,
	output logic                      o_data_valid,
	output logic [23:0]               o_data_addr,
	output logic [7:0]                o_data_seg_pins,
	output logic                      o_gpr_valid,
	output logic [15:0]               o_gpr_addr,
	output logic [15:0]               o_sfr_rdata
);
	import cag_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Keeps only the segment bits that the chosen pin count uses
	function automatic logic [7:0] pin_mask(input logic [7:0] seg, input cag_pins_e mode);
		logic [7:0] r;
		r = seg;
		case (mode)
			CAG_PINS_4: r = {4'h0, seg[3:0]};
			CAG_PINS_2: r = {6'h00, seg[1:0]};
			default:    r = seg;
		endcase
		return r;
	endfunction : pin_mask

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	cag_psw_s   processor_status_word;
	cag_psw_s   next_psw;
	logic       accept;
	logic       preempt;
	logic       next_accept;
	logic       next_preempt;

	// Return restores the stacked word, entry loads the level, software last
	always_comb begin
		next_psw = processor_status_word;
		if (i_interrupt_return_instr) begin
			next_psw = i_interrupt_return_instr_psw;
		end else if (i_isr_entry) begin
			next_psw.cpu_priority_level = i_isr_level;
		end else if (i_sfr_wr && i_sfr_sel == CAG_SEL_STATUS) begin
			next_psw = cag_psw_s'(i_sfr_wdata[CAG_LVL_W:0]);
		end
		// A request must beat the current level; at level 15 nothing can
		next_accept  = i_irq_req && processor_status_word.global_irq_enable && (i_irq_level > processor_status_word.cpu_priority_level);
		next_preempt = i_hw_trap || i_nmi || next_accept;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			processor_status_word     <= '{global_irq_enable: 1'b0, cpu_priority_level: CAG_LVL_RST};
			accept  <= 1'b0;
			preempt <= 1'b0;
		end else begin
			processor_status_word     <= next_psw;
			accept  <= next_accept;
			preempt <= next_preempt;
		end
	end

	// ----------------------------------------
	// Fetch offset and code segment
	// ----------------------------------------
	logic [15:0] ip;
	logic [15:0] next_ip;
	logic [7:0]  code_segment_register;
	logic [7:0]  next_csp;
	logic [23:0] code_addr;
	logic [23:0] next_code_addr;
	logic [7:0]  code_pins;
	logic [7:0]  next_code_pins;

	// Offset is not on the special register port at all
	always_comb begin
		next_ip = ip;
		if (i_ret_ip) begin
			next_ip = i_ret_ip_value;
		end else if (i_branch) begin
			next_ip = i_branch_target;
		end else if (i_fetch_done) begin
			next_ip = ip + {13'h0000, i_fetch_bytes};
		end
		// Clearing on interrupt wins: the vector always lives in segment zero
		next_csp = code_segment_register;
		if (i_isr_entry || i_sw_trap) begin
			next_csp = CAG_SEG_RST;
		end else if (i_long_xfer || i_seg_restore) begin
			next_csp = i_seg_value;
		end
		if (i_segmented) begin
			next_code_addr = {next_csp, next_ip};
			next_code_pins = pin_mask(next_csp, i_pin_mode);
		end else begin
			next_code_addr = {CAG_SEG_RST, next_ip};
			next_code_pins = CAG_SEG_RST;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ip        <= CAG_IP_RST;
			code_segment_register       <= CAG_SEG_RST;
			code_addr <= '0;
			code_pins <= CAG_SEG_RST;
		end else begin
			ip        <= next_ip;
			code_segment_register       <= next_csp;
			code_addr <= next_code_addr;
			code_pins <= next_code_pins;
		end
	end

	// ----------------------------------------
	// Page pointers and bank base
	// ----------------------------------------
	// Each entry keeps the written value and a copy that address math uses.
	// The copy takes the write at the second instruction boundary, counting one in the write cycle, which
	// matches the pipeline: the instruction right after the write sees old.
	logic [15:0] arch [CAG_ENTRIES];
	logic [15:0] used [CAG_ENTRIES];

	for (genvar e = 0; e < CAG_ENTRIES; e++) begin : g_entry
		localparam logic [15:0] RST = (e == CAG_CP_IDX) ? CAG_CP_RST : 16'(e);
		logic        hit;
		logic [15:0] wval;
		logic [15:0] next_arch;
		logic [15:0] next_used;
		logic [1:0]  age;
		logic [1:0]  next_age;

		always_comb begin
			hit  = i_sfr_wr && (i_sfr_sel == cag_sel_e'(3'(e)));
			wval = i_sfr_wdata & CAG_DPP_MASK;
			if (e == CAG_CP_IDX) begin
				wval = i_sfr_wdata;
				if (i_sfr_wdata[11:9] == CAG_CP_LOW3) begin
					wval[11:10] = CAG_CP_FORCE;
				end
			end
			next_arch = hit ? wval : arch[e];
			next_age  = age;
			if (hit) begin
				next_age = i_instr_end ? 2'h1 : 2'h2;
			end else if (i_instr_end && age != 2'h0) begin
				next_age = age - 2'h1;
			end
			next_used = used[e];
			if (!hit && next_age == 2'h0) begin
				next_used = arch[e];
			end
		end

		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				arch[e] <= RST;
				used[e] <= RST;
				age     <= 2'h0;
			end else begin
				arch[e] <= next_arch;
				used[e] <= next_used;
				age     <= next_age;
			end
		end
	end

	// ----------------------------------------
	// Data address translation
	// ----------------------------------------
	logic                  data_valid;
	logic                  next_data_valid;
	logic [23:0]           data_addr;
	logic [23:0]           next_data_addr;
	logic [7:0]            data_pins;
	logic [7:0]            next_data_pins;
	logic [CAG_PAGE_W-1:0] page;

	// Override and PERIPHERAL_EVENT_TRANSFER addresses already carry their full physical form
	always_comb begin
		page            = used[i_data_addr[15:14]][CAG_PAGE_W-1:0];
		next_data_valid = i_data_req;
		next_data_addr  = data_addr;
		next_data_pins  = data_pins;
		if (i_data_req) begin
			if (i_data_bypass) begin
				next_data_addr = i_data_far_addr;
			end else if (i_segmented) begin
				next_data_addr = {page, i_data_addr[CAG_OFS_W-1:0]};
			end else begin
				next_data_addr = {8'h00, page[1:0], i_data_addr[CAG_OFS_W-1:0]};
			end
			next_data_pins = i_segmented ? pin_mask(next_data_addr[23:16], i_pin_mode) : CAG_SEG_RST;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			data_valid <= 1'b0;
			data_addr  <= '0;
			data_pins  <= CAG_SEG_RST;
		end else begin
			data_valid <= next_data_valid;
			data_addr  <= next_data_addr;
			data_pins  <= next_data_pins;
		end
	end

	// ----------------------------------------
	// Short register resolution and read port
	// ----------------------------------------
	logic        gpr_valid;
	logic        next_gpr_valid;
	logic [15:0] gpr_addr;
	logic [15:0] next_gpr_addr;
	logic [3:0]  gpr_idx;
	logic [15:0] rdata;
	logic [15:0] next_rdata;

	// Long register numbers outside F0..FF are not registers of the bank
	always_comb begin
		gpr_idx        = i_gpr_num[3:0];
		next_gpr_valid = i_gpr_req && (!i_gpr_long || i_gpr_num[7:4] == CAG_GPR_RANGE);
		next_gpr_addr  = gpr_addr;
		if (next_gpr_valid) begin
			next_gpr_addr = used[CAG_CP_IDX] +
				(i_gpr_byte ? {12'h000, gpr_idx} : {11'h000, gpr_idx, 1'b0});
		end
		case (i_sfr_rd_sel)
			CAG_SEL_DATA_PAGE_POINTER_0,
			CAG_SEL_DATA_PAGE_POINTER_1,
			CAG_SEL_DATA_PAGE_POINTER_2,
			CAG_SEL_DATA_PAGE_POINTER_3:   next_rdata = arch[i_sfr_rd_sel[1:0]];
			CAG_SEL_CP:     next_rdata = arch[CAG_CP_IDX];
			CAG_SEL_CSP:    next_rdata = {8'h00, code_segment_register};
			CAG_SEL_STATUS: next_rdata = {11'h000, processor_status_word};
			default:        next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gpr_valid <= 1'b0;
			gpr_addr  <= '0;
			rdata     <= '0;
		end else begin
			gpr_valid <= next_gpr_valid;
			gpr_addr  <= next_gpr_addr;
			rdata     <= next_rdata;
		end
	end

	// Outputs, all straight from flops
	assign o_global_irq_enable  = processor_status_word.global_irq_enable;
	assign o_cpu_priority_level = processor_status_word.cpu_priority_level;
	assign o_maskable_accept    = accept;
	assign o_preempt            = preempt;
	assign o_fetch_offset       = ip;
	assign o_code_addr          = code_addr;
	assign o_code_seg_pins      = code_pins;
	assign o_data_valid         = data_valid;
	assign o_data_addr          = data_addr;
	assign o_data_seg_pins      = data_pins;
	assign o_gpr_valid          = gpr_valid;
	assign o_gpr_addr           = gpr_addr;
	assign o_sfr_rdata          = rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	chk_irq_gate: assert property (!processor_status_word.global_irq_enable |=> !accept)
		else $error("maskable interrupt accepted while disabled");
	chk_level_load: assert property (i_isr_entry && !i_interrupt_return_instr |=> processor_status_word.cpu_priority_level == $past(i_isr_level))
		else $error("priority level not loaded on entry");
	chk_level_top: assert property (processor_status_word.cpu_priority_level == CAG_LVL_TOP && !i_hw_trap && !i_nmi |=> !preempt)
		else $error("level 15 preempted by maskable request");
	chk_ip_step: assert property (i_fetch_done && !i_branch && !i_ret_ip |=> ip == $past(ip) + 16'($past(i_fetch_bytes)))
		else $error("fetch offset did not advance");
	// The address flop saw the mode of the cycle before, not the one now
	chk_code_addr: assert property (code_addr == ($past(i_segmented) ? {code_segment_register, ip} : {8'h00, ip}))
		else $error("code address mismatch");
	// Outside segmented mode the code segment pins must stay quiet
	chk_nonseg_pins: assert property (!i_segmented |=> code_pins == 8'h00)
		else $error("segment pins driven in non-segmented mode");
	chk_csp_clear: assert property (i_isr_entry || i_sw_trap |=> code_segment_register == 8'h00 ##1 code_pins == 8'h00 || $past(i_long_xfer || i_seg_restore))
		else $error("code segment not cleared");
	chk_csp_no_write: assert property (i_sfr_wr && !i_long_xfer && !i_seg_restore && !i_isr_entry && !i_sw_trap
		|=> $stable(code_segment_register))
		else $error("data write changed code segment");
	chk_page_xlate: assert property (i_data_req && !i_data_bypass && i_segmented
		|=> data_valid && data_addr[13:0] == $past(i_data_addr[13:0]))
		else $error("page offset bits lost");
	chk_cp_force: assert property (i_sfr_wr && i_sfr_sel == CAG_SEL_CP && i_sfr_wdata[11:9] == 3'h0
		|=> arch[CAG_CP_IDX][11:10] == 2'h3)
		else $error("bank base bits not forced");
	chk_old_dpp: assert property (i_sfr_wr && i_sfr_sel == CAG_SEL_DATA_PAGE_POINTER_0 && !i_instr_end
		|=> used[0] == $past(used[0]))
		else $error("new page pointer used too early");

	// Return wins over entry and software, so the whole stacked word comes back
	chk_psw_restore: assert property (i_interrupt_return_instr |=> processor_status_word == $past(i_interrupt_return_instr_psw))
		else $error("status not restored on return");

	// Override and event transfers must pass through untranslated
	chk_data_bypass: assert property (i_data_req && i_data_bypass
		|=> data_valid && data_addr == $past(i_data_far_addr))
		else $error("bypass address was translated");

	// Word registers sit two bytes apart above the bank base in use
	chk_gpr_word: assert property (i_gpr_req && !i_gpr_long && !i_gpr_byte
		|=> gpr_valid && gpr_addr == $past(used[CAG_CP_IDX]) + {11'h000, $past(i_gpr_num[3:0]), 1'b0})
		else $error("word register address wrong");

	cov_isr_entry:  cover property (i_isr_entry ##1 i_interrupt_return_instr);
	cov_paged_read: cover property (i_sfr_wr && i_sfr_sel == CAG_SEL_DATA_PAGE_POINTER_2 ##[1:8] i_instr_end ##[1:8] i_instr_end);
	cov_gpr_long:   cover property (i_gpr_req && i_gpr_long && i_gpr_num[7:4] == 4'hf);
	// Top level still lets a trap through
	cov_level_top:  cover property (processor_status_word.cpu_priority_level == CAG_LVL_TOP && i_hw_trap);
	cov_bypass:     cover property (i_data_req && i_data_bypass);

endmodule : cag_addr_gen

// file: tb/cag_pipe_model.sv
`timescale 1ns/1ps
// Pipeline side: marks instruction boundaries, promptly or after a stall
module cag_pipe_model (
	input  wire logic i_clk,
	output logic      o_instr_end
);
	initial o_instr_end = 1'h0;

	// One boundary pulse after gap idle cycles; a slow pipe just waits longer
	task automatic end_instr(input int gap);
		repeat (gap) @(posedge i_clk);
		@(posedge i_clk);
		o_instr_end <= 1'h1;
		@(posedge i_clk);
		o_instr_end <= 1'h0;
	endtask : end_instr
endmodule : cag_pipe_model

// file: tb/cag_addr_gen_bench.sv
`timescale 1ns/1ps
module cag_addr_gen_bench;
	import cag_pkg::*;
	logic        i_clk, i_arst_n, i_segmented, i_instr_end, i_sfr_wr, i_isr_entry, i_sw_trap, i_interrupt_return_instr;
	logic        i_irq_req, i_hw_trap, i_nmi, i_fetch_done, i_branch, i_ret_ip, i_long_xfer, i_seg_restore;
	logic        i_data_req, i_data_bypass, i_gpr_req, i_gpr_long, i_gpr_byte;
	logic [15:0] i_sfr_wdata, i_branch_target, i_ret_ip_value, i_data_addr;
	logic [3:0]  i_isr_level, i_irq_level;
	logic [7:0]  i_seg_value, i_gpr_num;
	logic [2:0]  i_fetch_bytes;
	logic [23:0] i_data_far_addr;
	cag_pins_e   i_pin_mode;
	cag_sel_e    i_sfr_sel, i_sfr_rd_sel;
	cag_psw_s    i_interrupt_return_instr_psw;
	logic        o_global_irq_enable, o_maskable_accept, o_preempt, o_data_valid, o_gpr_valid;
	logic [3:0]  o_cpu_priority_level;
	logic [15:0] o_fetch_offset, o_gpr_addr, o_sfr_rdata;
	logic [23:0] o_code_addr, o_data_addr;
	logic [7:0]  o_code_seg_pins, o_data_seg_pins;
	int          n_errors, tests_run, cycles;

	cag_pipe_model u_pipe (.i_clk, .o_instr_end(i_instr_end));

	cag_addr_gen DUT (
		.i_clk, .i_arst_n, .i_segmented, .i_pin_mode, .i_instr_end, .i_sfr_wr, .i_sfr_sel, .i_sfr_wdata,
		.i_sfr_rd_sel, .i_isr_entry, .i_isr_level, .i_sw_trap, .i_interrupt_return_instr, .i_interrupt_return_instr_psw, .i_irq_req,
		.i_irq_level, .i_hw_trap, .i_nmi, .i_fetch_done, .i_fetch_bytes, .i_branch, .i_branch_target,
		.i_ret_ip, .i_ret_ip_value, .i_long_xfer, .i_seg_restore, .i_seg_value, .i_data_req, .i_data_addr,
		.i_data_bypass, .i_data_far_addr, .i_gpr_req, .i_gpr_num, .i_gpr_long, .i_gpr_byte,
		.o_global_irq_enable, .o_cpu_priority_level, .o_maskable_accept, .o_preempt, .o_fetch_offset,
		.o_code_addr, .o_code_seg_pins, .o_data_valid, .o_data_addr, .o_data_seg_pins, .o_gpr_valid,
		.o_gpr_addr, .o_sfr_rdata
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Drops every pulse except the interrupt request, trap and NMI inputs at the next edge, then lets registered outputs settle
	task automatic clr();
		@(posedge i_clk);
		{i_sfr_wr, i_isr_entry, i_sw_trap, i_interrupt_return_instr, i_fetch_done, i_branch} <= 6'h00;
		{i_ret_ip, i_long_xfer, i_seg_restore, i_data_req, i_gpr_req} <= 5'h00;
		#1;
	endtask : clr

	task automatic sfr_wr(input cag_sel_e sel, input logic [15:0] d);
		@(posedge i_clk);
		i_sfr_wr <= 1'h1;
		i_sfr_sel <= sel;
		i_sfr_wdata <= d;
		clr();
	endtask : sfr_wr

	// Read data answers one cycle after the select is driven
	task automatic rd(input cag_sel_e sel, input logic [15:0] exp);
		@(posedge i_clk);
		i_sfr_rd_sel <= sel;
		@(posedge i_clk);
		#1;
		chk(sel.name(), {8'h00, o_sfr_rdata}, {8'h00, exp});
	endtask : rd

	task automatic irq(input logic r, input logic [3:0] l, input logic t, input logic n, input logic ea, input logic ep);
		@(posedge i_clk);
		i_irq_req <= r;
		i_irq_level <= l;
		i_hw_trap <= t;
		i_nmi <= n;
		@(posedge i_clk);
		{i_irq_req, i_hw_trap, i_nmi} <= 3'h0;
		#1;
		chk("accept", {23'h0, o_maskable_accept}, {23'h0, ea});
		chk("preempt", {23'h0, o_preempt}, {23'h0, ep});
	endtask : irq

	task automatic step(input logic s, input cag_pins_e m, input logic [2:0] b);
		@(posedge i_clk);
		i_segmented <= s;
		i_pin_mode <= m;
		i_fetch_done <= 1'h1;
		i_fetch_bytes <= b;
		clr();
	endtask : step

	task automatic dchk(input cag_pins_e m, input logic s, input logic [15:0] a, input logic [23:0] ea,
			input logic [7:0] ep);
		@(posedge i_clk);
		i_pin_mode <= m;
		i_segmented <= s;
		i_data_req <= 1'h1;
		i_data_bypass <= 1'h0;
		i_data_addr <= a;
		clr();
		chk("data valid", {23'h0, o_data_valid}, 24'h000001);
		chk("data addr", o_data_addr, ea);
		chk("data pins", {16'h0, o_data_seg_pins}, {16'h0, ep});
	endtask : dchk

	task automatic gchk(input logic [7:0] n, input logic lg, input logic by, input logic ev, input logic [15:0] ea);
		@(posedge i_clk);
		i_gpr_req <= 1'h1;
		i_gpr_num <= n;
		i_gpr_long <= lg;
		i_gpr_byte <= by;
		clr();
		chk("reg valid", {23'h0, o_gpr_valid}, {23'h0, ev});
		if (ev) begin
			chk("reg addr", {8'h00, o_gpr_addr}, {8'h00, ea});
		end
	endtask : gchk

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		i_clk = 1'h0;
		forever #2 i_clk = ~i_clk;
	end

	// Hang guard: the sequence needs only about 115 cycles
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{i_arst_n, i_segmented, i_irq_req, i_hw_trap, i_nmi, i_data_bypass, i_gpr_long, i_gpr_byte} = 8'h00;
		{i_sfr_wr, i_isr_entry, i_sw_trap, i_interrupt_return_instr, i_fetch_done, i_branch} = 6'h00;
		{i_ret_ip, i_long_xfer, i_seg_restore, i_data_req, i_gpr_req} = 5'h00;
		{i_sfr_wdata, i_branch_target, i_ret_ip_value, i_data_addr} = 64'h0;
		{i_isr_level, i_irq_level, i_seg_value, i_gpr_num, i_fetch_bytes, i_data_far_addr} = 51'h0;
		i_pin_mode = CAG_PINS_8;
		i_sfr_sel = CAG_SEL_DATA_PAGE_POINTER_0;
		i_sfr_rd_sel = CAG_SEL_DATA_PAGE_POINTER_0;
		i_interrupt_return_instr_psw = 5'h00;
		repeat (12) @(posedge i_clk);
		i_arst_n <= 1'h1;
		chk("enable", {23'h0, o_global_irq_enable}, 24'h0);
		chk("level", {20'h0, o_cpu_priority_level}, 24'h0);
		for (int k = 0; k < 4; k++) begin
			rd(cag_sel_e'(k), 16'(k));
		end
		rd(CAG_SEL_STATUS, 16'h0000);
		dchk(CAG_PINS_8, 1'h1, 16'hc123, 24'h00c123, 8'h00);
		// Interrupt status and acceptance threshold
		sfr_wr(CAG_SEL_STATUS, 16'h0015);
		chk("level", {20'h0, o_cpu_priority_level}, 24'h5);
		irq(1'h1, 4'h6, 1'h0, 1'h0, 1'h1, 1'h1);
		irq(1'h1, 4'h5, 1'h0, 1'h0, 1'h0, 1'h0);
		sfr_wr(CAG_SEL_STATUS, 16'h0005);
		irq(1'h1, 4'hf, 1'h0, 1'h0, 1'h0, 1'h0);
		sfr_wr(CAG_SEL_STATUS, 16'h001f);
		irq(1'h1, 4'hf, 1'h0, 1'h0, 1'h0, 1'h0);
		irq(1'h0, 4'h0, 1'h1, 1'h0, 1'h0, 1'h1);
		irq(1'h0, 4'h0, 1'h0, 1'h1, 1'h0, 1'h1);
		// Code addressing: long jump, fetch advance, pin widths
		@(posedge i_clk);
		i_segmented <= 1'h1;
		i_long_xfer <= 1'h1;
		i_seg_value <= 8'h12;
		i_branch <= 1'h1;
		i_branch_target <= 16'h0100;
		clr();
		chk("code addr", o_code_addr, 24'h120100);
		chk("code pins", {16'h0, o_code_seg_pins}, 24'h12);
		step(1'h1, CAG_PINS_8, 3'h4);
		chk("offset", {8'h00, o_fetch_offset}, 24'h0104);
		step(1'h1, CAG_PINS_4, 3'h2);
		chk("code pins", {16'h0, o_code_seg_pins}, 24'h02);
		step(1'h1, CAG_PINS_2, 3'h2);
		chk("code pins", {16'h0, o_code_seg_pins}, 24'h02);
		step(1'h0, CAG_PINS_8, 3'h2);
		chk("code addr", o_code_addr, 24'h00010a);
		chk("code pins", {16'h0, o_code_seg_pins}, 24'h0);
		sfr_wr(CAG_SEL_CSP, 16'hffff);
		rd(CAG_SEL_CSP, 16'h0012);
		// Entry clears the segment even against a same-cycle restore
		@(posedge i_clk);
		i_isr_entry <= 1'h1;
		i_isr_level <= 4'h7;
		i_seg_restore <= 1'h1;
		clr();
		chk("level", {20'h0, o_cpu_priority_level}, 24'h7);
		rd(CAG_SEL_CSP, 16'h0000);
		@(posedge i_clk);
		i_segmented <= 1'h1;
		i_interrupt_return_instr <= 1'h1;
		i_interrupt_return_instr_psw <= 5'h13;
		i_ret_ip <= 1'h1;
		i_ret_ip_value <= 16'h2000;
		i_seg_restore <= 1'h1;
		i_seg_value <= 8'h34;
		clr();
		chk("enable", {23'h0, o_global_irq_enable}, 24'h1);
		chk("level", {20'h0, o_cpu_priority_level}, 24'h3);
		chk("code addr", o_code_addr, 24'h342000);
		@(posedge i_clk);
		i_sw_trap <= 1'h1;
		i_long_xfer <= 1'h1;
		clr();
		rd(CAG_SEL_CSP, 16'h0000);
		// Data paging with the two-boundary lag
		sfr_wr(CAG_SEL_DATA_PAGE_POINTER_1, 16'hffff);
		rd(CAG_SEL_DATA_PAGE_POINTER_1, 16'h03ff);
		dchk(CAG_PINS_8, 1'h1, 16'h4010, 24'h004010, 8'h00);
		u_pipe.end_instr(0);
		dchk(CAG_PINS_8, 1'h1, 16'h4010, 24'h004010, 8'h00);
		u_pipe.end_instr(3);
		dchk(CAG_PINS_8, 1'h1, 16'h4010, 24'hffc010, 8'hff);
		dchk(CAG_PINS_4, 1'h1, 16'h4010, 24'hffc010, 8'h0f);
		dchk(CAG_PINS_2, 1'h1, 16'h4010, 24'hffc010, 8'h03);
		dchk(CAG_PINS_8, 1'h0, 16'h4010, 24'h00c010, 8'h00);
		@(posedge i_clk);
		i_data_req <= 1'h1;
		i_data_bypass <= 1'h1;
		i_data_far_addr <= 24'h5a4321;
		clr();
		chk("data addr", o_data_addr, 24'h5a4321);
		// Register bank base and short register numbers
		sfr_wr(CAG_SEL_CP, 16'h1000);
		rd(CAG_SEL_CP, 16'h1c00);
		gchk(8'h03, 1'h0, 1'h0, 1'h1, 16'hfc06);
		u_pipe.end_instr(0);
		u_pipe.end_instr(1);
		gchk(8'h03, 1'h0, 1'h0, 1'h1, 16'h1c06);
		gchk(8'h05, 1'h0, 1'h1, 1'h1, 16'h1c05);
		gchk(8'hf3, 1'h1, 1'h0, 1'h1, 16'h1c06);
		gchk(8'h23, 1'h1, 1'h0, 1'h0, 16'h0000);
		sfr_wr(CAG_SEL_CP, 16'h1200);
		rd(CAG_SEL_CP, 16'h1200);
		tally_and_finish();
	end
endmodule : cag_addr_gen_bench
